//--- core/dmac_pkg.sv
// package for the debug memory-access command interpreter
package dmac_pkg;
	localparam logic [7:0]  DMAC_OP_RD_REG  = 8'h09;
	localparam logic [7:0]  DMAC_OP_WR_PROG = 8'h0a;
	localparam logic [7:0]  DMAC_OP_RD_PROG = 8'h0b;
	localparam logic [7:0]  DMAC_OP_WR_DATA = 8'h0c;
	localparam logic [7:0]  DMAC_BLANK_BYTE = 8'hff;
	localparam logic [3:0]  DMAC_REG_HI_PAD = 4'h0;
	localparam logic [16:0] DMAC_REG_SZ_ZERO = 17'h00100;
	localparam logic [16:0] DMAC_MEM_SZ_ZERO = 17'h10000;
	localparam logic [16:0] DMAC_ONE        = 17'h00001;

	typedef enum logic [1:0] {
		DMAC_SP_REG  = 2'b00,
		DMAC_SP_PROG = 2'b01,
		DMAC_SP_DATA = 2'b10
	} dmac_space_t;

	// one memory request toward the core's memories
	typedef struct packed {
		logic        valid;
		logic        write;
		dmac_space_t space;
		logic [15:0] addr;
		logic [7:0]  wdata;
	} dmac_mreq_t;

	// one byte on the debug serial line, either direction
	typedef struct packed {
		logic       valid;
		logic [7:0] data;
	} dmac_byte_t;
endpackage : dmac_pkg

//--- core/dmac_gate.sv
// access gate: decides blanking of reads and discarding of writes
`timescale 1ns/1ps
`default_nettype none
module dmac_gate (
	// access state
	input  wire logic              debug_mode,
	input  wire logic              read_protect,
	input  wire logic              flash_unlocked,
	input  wire dmac_pkg::dmac_space_t space,
	// decisions
	output logic                   blank_read,
	output logic                   allow_write
);
	import dmac_pkg::*;
	always_comb begin
		blank_read  = !debug_mode || read_protect; // RULE_02 RULE_07
		allow_write = debug_mode && !read_protect; // RULE_05
		if (space == DMAC_SP_PROG) begin
			allow_write = allow_write && flash_unlocked; // RULE_04
		end
	end
endmodule : dmac_gate
`default_nettype wire

//--- core/dmac_core.sv
// debug memory-access command interpreter
// Operation
// [RULE_01] 09H: pad/addr-hi, addr-lo, size; returns bytes
// [RULE_02] register read blanked to FFH when locked out
// [RULE_03] 0AH: addr, size 16-bit, then data bytes
// [RULE_04] program writes dropped unless flash unlocked
// [RULE_05] writes dropped outside debug or read-protected
// [RULE_06] 0BH: addr, size 16-bit; returns bytes
// [RULE_07] program read blanked to FFH when locked out
// [RULE_08] 0CH: data address high byte first
// [RULE_09] data write then size 16-bit and data
`timescale 1ns/1ps
`default_nettype none
module dmac_core (
	// clock and reset
	input  wire logic                 clock,
	input  wire logic                 sys_rst,
	// access state, synchronous to clock
	input  wire logic                 debug_mode,
	input  wire logic                 read_protect,
	input  wire logic                 flash_unlocked,
	// command bytes from the debug serial line receiver
	input  wire dmac_pkg::dmac_byte_t rx_byte,
	// reply bytes to the debug serial line transmitter
	output dmac_pkg::dmac_byte_t      tx_byte,
	input  wire logic                 tx_ready,
	// memory port
	output dmac_pkg::dmac_mreq_t      mem_req,
	input  wire logic                 mem_rvalid,
	input  wire logic [7:0]           mem_rdata,
	// status
	output logic                      busy
);
	import dmac_pkg::*;

	typedef enum logic [2:0] {
		DMAC_IDLE    = 3'b000,
		DMAC_ADDR_HI = 3'b001,
		DMAC_ADDR_LO = 3'b010,
		DMAC_SIZE_HI = 3'b011,
		DMAC_SIZE_LO = 3'b100,
		DMAC_WDATA   = 3'b101,
		DMAC_RFETCH  = 3'b110,
		DMAC_RSEND   = 3'b111
	} dmac_state_t;

	dmac_state_t state_r;
	dmac_space_t space_r;
	logic        is_read_r;
	logic [15:0] addr_r;
	logic [16:0] count_r;
	logic [7:0]  size_hi_r;
	logic        wait_r;
	dmac_byte_t  tx_r;
	dmac_mreq_t  req_r;
	logic        blank_read;
	logic        allow_write;

	// 17-bit count: zero size means the full range
	function automatic logic [16:0] dmac_size(input logic [15:0] sz, input logic is_reg);
		if (sz == 16'h0000) begin
			dmac_size = is_reg ? DMAC_REG_SZ_ZERO : DMAC_MEM_SZ_ZERO;
		end else begin
			dmac_size = {1'b0, sz};
		end
	endfunction : dmac_size

	dmac_gate u_gate (
		.debug_mode     (debug_mode),
		.read_protect   (read_protect),
		.flash_unlocked (flash_unlocked),
		.space          (space_r),
		.blank_read     (blank_read),
		.allow_write    (allow_write)
	);

	// command parsing and sequencing
	always_ff @(posedge clock) begin
		if (sys_rst) begin
			state_r   <= DMAC_IDLE;
			space_r   <= DMAC_SP_REG;
			is_read_r <= 1'b0;
			addr_r    <= 16'h0000;
			count_r   <= 17'h00000;
			size_hi_r <= 8'h00;
		end else begin
			unique case (state_r)
				DMAC_IDLE: begin
					if (rx_byte.valid) begin
						state_r <= DMAC_ADDR_HI;
						unique case (rx_byte.data)
							DMAC_OP_RD_REG: begin
								space_r   <= DMAC_SP_REG; // RULE_01
								is_read_r <= 1'b1;
							end
							DMAC_OP_WR_PROG: begin
								space_r   <= DMAC_SP_PROG; // RULE_03
								is_read_r <= 1'b0;
							end
							DMAC_OP_RD_PROG: begin
								space_r   <= DMAC_SP_PROG; // RULE_06
								is_read_r <= 1'b1;
							end
							DMAC_OP_WR_DATA: begin
								space_r   <= DMAC_SP_DATA; // RULE_08
								is_read_r <= 1'b0;
							end
							default: state_r <= DMAC_IDLE;
						endcase
					end
				end
				DMAC_ADDR_HI: begin
					if (rx_byte.valid) begin
						// register space keeps only address bits 11:8
						if (space_r == DMAC_SP_REG) begin
							addr_r[15:8] <= {DMAC_REG_HI_PAD, rx_byte.data[3:0]}; // RULE_01
						end else begin
							addr_r[15:8] <= rx_byte.data; // RULE_08
						end
						state_r <= DMAC_ADDR_LO;
					end
				end
				DMAC_ADDR_LO: begin
					if (rx_byte.valid) begin
						addr_r[7:0] <= rx_byte.data;
						state_r     <= (space_r == DMAC_SP_REG) ? DMAC_SIZE_LO : DMAC_SIZE_HI;
						size_hi_r   <= 8'h00;
					end
				end
				DMAC_SIZE_HI: begin
					if (rx_byte.valid) begin
						size_hi_r <= rx_byte.data; // RULE_03 RULE_06 RULE_09
						state_r   <= DMAC_SIZE_LO;
					end
				end
				DMAC_SIZE_LO: begin
					if (rx_byte.valid) begin
						count_r <= dmac_size({size_hi_r, rx_byte.data}, space_r == DMAC_SP_REG);
						state_r <= is_read_r ? DMAC_RFETCH : DMAC_WDATA;
					end
				end
				DMAC_WDATA: begin
					if (rx_byte.valid) begin
						addr_r  <= addr_r + 16'h0001;
						count_r <= count_r - DMAC_ONE;
						if (count_r == DMAC_ONE) begin
							state_r <= DMAC_IDLE;
						end
					end
				end
				DMAC_RFETCH: begin
					// blanked reads skip the memory entirely
					if (blank_read || (wait_r && mem_rvalid)) begin
						state_r <= DMAC_RSEND; // RULE_02 RULE_07
					end
				end
				DMAC_RSEND: begin
					if (tx_ready) begin
						addr_r  <= addr_r + 16'h0001;
						count_r <= count_r - DMAC_ONE;
						state_r <= (count_r == DMAC_ONE) ? DMAC_IDLE : DMAC_RFETCH;
					end
				end
			endcase
		end
	end

	// memory request issue
	always_ff @(posedge clock) begin
		if (sys_rst) begin
			req_r  <= '0;
			wait_r <= 1'b0;
		end else begin
			req_r.valid <= 1'b0;
			if (state_r == DMAC_WDATA && rx_byte.valid && allow_write) begin
				req_r.valid <= 1'b1; // RULE_04 RULE_05
				req_r.write <= 1'b1;
				req_r.space <= space_r;
				req_r.addr  <= addr_r;
				req_r.wdata <= rx_byte.data;
			end else if (state_r == DMAC_RFETCH && !blank_read && !wait_r) begin
				req_r.valid <= 1'b1;
				req_r.write <= 1'b0;
				req_r.space <= space_r;
				req_r.addr  <= addr_r;
				req_r.wdata <= 8'h00;
				wait_r      <= 1'b1;
			end else if (mem_rvalid) begin
				// any strobe ends the wait, also one landing after gating blanked the fetch
				wait_r <= 1'b0;
			end
		end
	end

	// reply byte; held until the transmitter takes it
	always_ff @(posedge clock) begin
		if (sys_rst) begin
			tx_r <= '0;
		end else if (state_r == DMAC_RFETCH && blank_read) begin
			tx_r <= '{valid: 1'b1, data: DMAC_BLANK_BYTE}; // RULE_02 RULE_07
		end else if (state_r == DMAC_RFETCH && wait_r && mem_rvalid) begin
			tx_r <= '{valid: 1'b1, data: mem_rdata};
		end else if (state_r == DMAC_RSEND && tx_ready) begin
			tx_r.valid <= 1'b0;
		end
	end

	// busy also covers the cycle after an opcode is taken
	always_ff @(posedge clock) begin
		if (sys_rst) begin
			busy <= 1'b0;
		end else begin
			busy <= (state_r != DMAC_IDLE) || rx_byte.valid;
		end
	end

	assign tx_byte = tx_r;
	assign mem_req = req_r;
endmodule : dmac_core
`default_nettype wire

//--- verification/dmac_core_asserts.sv
// port assertions for the memory-access interpreter
`timescale 1ns/1ps
`default_nettype none
module dmac_core_asserts (
	// clock and reset
	input wire logic                 clock,
	input wire logic                 sys_rst,
	// access state
	input wire logic                 debug_mode,
	input wire logic                 read_protect,
	input wire logic                 flash_unlocked,
	// debug serial line bytes
	input wire dmac_pkg::dmac_byte_t rx_byte,
	input wire dmac_pkg::dmac_byte_t tx_byte,
	input wire logic                 tx_ready,
	// memory port
	input wire dmac_pkg::dmac_mreq_t mem_req,
	input wire logic                 mem_rvalid,
	input wire logic [7:0]           mem_rdata,
	// status
	input wire logic                 busy
);
	import dmac_pkg::*;
	wire logic wr = mem_req.valid & mem_req.write;
	wire logic rd = mem_req.valid & ~mem_req.write;
	wire logic wp = wr & (mem_req.space == DMAC_SP_PROG);
	wire logic open_w = debug_mode & ~read_protect;
	// known opcode seen while idle
	wire logic op_w = rx_byte.valid & ~busy & (rx_byte.data - 8'h09 < 8'h04);
	default clocking @(posedge clock); endclocking
	default disable iff (sys_rst);
	sequence tx_new;
		tx_byte.valid && !$past(tx_byte.valid && !tx_ready);
	endsequence
	wr_gate_a: assert property (wr |-> $past(open_w)) else $error("wr gate");
	prog_lock_a: assert property (wp |-> $past(flash_unlocked)) else $error("lock");
	wr_data_a: assert property (wr |-> $past(rx_byte) == {1'b1, mem_req.wdata})
		else $error("wr data");
	rd_gate_a: assert property (rd |-> $past(open_w)) else $error("rd gate");
	blank_a: assert property (tx_new ##0 !$past(mem_rvalid)
		|-> tx_byte.data == DMAC_BLANK_BYTE) else $error("blank");
	rd_data_a: assert property (tx_new ##0 $past(mem_rvalid)
		|-> tx_byte.data == $past(mem_rdata)) else $error("rd data");
	tx_hold_a: assert property (tx_byte.valid && !tx_ready |=> $stable(tx_byte))
		else $error("tx hold");
	start_a: assert property (op_w |=> busy) else $error("start");
endmodule : dmac_core_asserts
`default_nettype wire

//--- verification/dmac_host.sv
// debug host model: frames commands, paces reply acceptance
`timescale 1ns/1ps
`default_nettype none
module dmac_host (
	// clock
	input  wire logic            clock,
	// command bytes and reply pacing
	output dmac_pkg::dmac_byte_t rx_byte,
	output logic                 tx_ready
);
	import dmac_pkg::*;
	logic slow = 1'b0;
	initial rx_byte = '0;
	initial tx_ready = 1'b0;
	// slow pacing takes a reply every other cycle
	always @(negedge clock) tx_ready <= slow ? !tx_ready : 1'b1;
	task send(input logic [7:0] b);
		@(negedge clock) rx_byte <= {1'b1, b};
		@(negedge clock) rx_byte <= {1'b0, ~b};
	endtask : send
	task cmd(input logic [7:0] op, input logic [15:0] a, input logic [16:0] n);
		send(op);
		if (op == DMAC_OP_RD_REG) send({DMAC_REG_HI_PAD, a[11:8]});
		else send(a[15:8]);
		send(a[7:0]);
		if (op != DMAC_OP_RD_REG) send(n[15:8]);
		send(n[7:0]);
		for (int i = 0; !op[0] && i < n; i++) send(8'(i) ^ 8'h5a);
	endtask : cmd
endmodule : dmac_host
`default_nettype wire

//--- verification/dmac_core_test.sv
// self-checking bench for the memory-access interpreter
`timescale 1ns/1ps
`default_nettype none
module dmac_core_test;
	import dmac_pkg::*;
	logic clock = 1'b0, sys_rst = 1'b1, debug_mode = 1'b0, read_protect = 1'b0;
	logic flash_unlocked = 1'b0, mem_rvalid = 1'b0, tx_ready, busy;
	logic [7:0] mem_rdata = 8'h00;
	logic [7:0] tq[$];
	dmac_byte_t rx_byte, tx_byte;
	dmac_mreq_t mem_req;
	dmac_mreq_t wq[$];
	int error_cnt = 0, checks_done = 0;
	always #12.5 clock = ~clock;
	dmac_core u_dut (
		.clock          (clock),
		.sys_rst        (sys_rst),
		.debug_mode     (debug_mode),
		.read_protect   (read_protect),
		.flash_unlocked (flash_unlocked),
		.rx_byte        (rx_byte),
		.tx_byte        (tx_byte),
		.tx_ready       (tx_ready),
		.mem_req        (mem_req),
		.mem_rvalid     (mem_rvalid),
		.mem_rdata      (mem_rdata),
		.busy           (busy)
	);
	dmac_host u_host (
		.clock    (clock),
		.rx_byte  (rx_byte),
		.tx_ready (tx_ready)
	);
	// memory answers a read one cycle on with an address pattern
	always @(negedge clock) begin
		mem_rvalid <= mem_req.valid && !mem_req.write;
		mem_rdata <= mem_req.addr[7:0] ^ 8'hc3;
	end
	always @(posedge clock) begin
		if (mem_req.valid && mem_req.write) wq.push_back(mem_req);
		if (tx_byte.valid && tx_ready) tq.push_back(tx_byte.data);
	end
	task chk(input logic [27:0] g, input logic [27:0] e);
		checks_done++;
		if (g !== e) error_cnt++;
		if (g !== e) $display("Error at %0t: got %h expected %h", $time, g, e);
	endtask : chk
	task go(input logic [2:0] g, input logic [7:0] op, input logic [15:0] a, input logic [16:0] n,
		input int k);
		logic [7:0] e;
		{debug_mode, read_protect, flash_unlocked} = g;
		wq = {};
		tq = {};
		u_host.cmd(op, a, n);
		for (int i = 0; i < 4000 && busy !== 1'b0; i++) @(negedge clock);
		chk(28'(wq.size() + tq.size()), 28'(k));
		for (int i = 0; i < k; i++) begin
			e = g[2:1] == 2'b10 ? 8'(a + 16'(i)) ^ 8'hc3 : DMAC_BLANK_BYTE;
			if (op[0]) chk({20'h0, tq[i]}, {20'h0, e});
			else chk(wq[i], {2'b11, op[2] ? DMAC_SP_DATA : DMAC_SP_PROG,
				a + 16'(i), 8'(i) ^ 8'h5a});
		end
	endtask : go
	task t_write;
		u_host.send(8'h0d);
		go(3'b101, DMAC_OP_WR_PROG, 16'hffff, 17'h2, 2);
		go(3'b100, DMAC_OP_WR_PROG, 16'h0010, 17'h1, 0);
		go(3'b100, DMAC_OP_WR_DATA, 16'h8001, 17'h3, 3);
		go(3'b111, DMAC_OP_WR_DATA, 16'h8001, 17'h1, 0);
	endtask : t_write
	task t_read;
		u_host.slow = 1'b1;
		go(3'b000, DMAC_OP_RD_REG, 16'h0f20, 17'h0, 256);
		go(3'b110, DMAC_OP_RD_REG, 16'h0a40, 17'h1, 1);
		go(3'b100, DMAC_OP_RD_REG, 16'h0a40, 17'h2, 2);
		go(3'b101, DMAC_OP_RD_PROG, 16'h12fe, 17'h3, 3);
		u_host.slow = 1'b0;
		go(3'b010, DMAC_OP_RD_PROG, 16'h1234, 17'h1, 1);
	endtask : t_read
	task results;
		$display("checks %0d errors %0d", checks_done, error_cnt);
		if (error_cnt == 0 && checks_done > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask : results
	initial begin
		#400us;
		error_cnt++;
		results();
	end
	initial begin
		repeat (4) @(negedge clock);
		sys_rst = 1'b0;
		t_write();
		t_read();
		results();
	end
endmodule : dmac_core_test
bind dmac_core dmac_core_asserts u_chk (
	.clock          (clock),
	.sys_rst        (sys_rst),
	.debug_mode     (debug_mode),
	.read_protect   (read_protect),
	.flash_unlocked (flash_unlocked),
	.rx_byte        (rx_byte),
	.tx_byte        (tx_byte),
	.tx_ready       (tx_ready),
	.mem_req        (mem_req),
	.mem_rvalid     (mem_rvalid),
	.mem_rdata      (mem_rdata),
	.busy           (busy)
);
`default_nettype wire
